// File: design/l2fe_pkg.sv
// shared constants and types of the layer-2 learning and forwarding engine
package l2fe_pkg;
   localparam int NPORT = 4;
   localparam int PORT_W = 2;
   localparam int BUF_DEPTH = 2048;
   localparam int BUF_AW = 11;
   localparam int LEN_W = 12;
   localparam int TBL_ENTRIES = 16;
   localparam int TBL_AW = 4;
   localparam int MAC_W = 48;
   localparam logic [LEN_W-1:0] DA_END = 12'h0006;
   localparam logic [LEN_W-1:0] HDR_BYTES = 12'h000C;
   localparam logic [LEN_W-1:0] BUF_LAST = 12'h07FF;
   // ability bits: 10 half, 10 full, 100 half, 100 full, 1000 full
   localparam int AB_W = 5;
   localparam int AB_10H = 0;
   localparam int AB_10F = 1;
   localparam int AB_100H = 2;
   localparam int AB_100F = 3;
   localparam int AB_1000F = 4;
   localparam logic [AB_W-1:0] LOCAL_ABILITY = 5'h1F;
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;
   localparam logic [TBL_AW-1:0] REPL_RESET = 4'h0;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_STORE = 2'b01,
      ST_DECIDE = 2'b11,
      ST_SEND = 2'b10
   } l2fe_state_t;
endpackage

// File: design/l2fe_addr_table.sv
// shared station address table with learning and lookup
`timescale 1ns/1ns
module l2fe_addr_table
   import l2fe_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [MAC_W-1:0] look_mac,
   output logic look_hit,
   output logic [PORT_W-1:0] look_port,
   input wire logic learn_en,
   input wire logic [MAC_W-1:0] learn_mac,
   input wire logic [PORT_W-1:0] learn_port
);
   typedef struct packed {
      logic [TBL_AW-1:0] repl;
   } l2fe_tbl_t;

   l2fe_tbl_t r;
   l2fe_tbl_t next_r;
   logic ent_vld [TBL_ENTRIES];
   logic [MAC_W-1:0] ent_mac [TBL_ENTRIES];
   logic [PORT_W-1:0] ent_port [TBL_ENTRIES];
   logic [TBL_ENTRIES-1:0] look_match;
   logic [TBL_ENTRIES-1:0] learn_match;
   logic learn_hit;
   logic [TBL_AW-1:0] learn_idx;

   genvar gi;
   generate
      for (gi = 0; gi < TBL_ENTRIES; gi++) begin : g_cmp
         assign look_match[gi] = ent_vld[gi] && (ent_mac[gi] == look_mac);
         assign learn_match[gi] = ent_vld[gi] && (ent_mac[gi] == learn_mac);
      end
   endgenerate

   always_comb begin
      next_r = r;
      look_hit = |look_match;
      look_port = '0;
      learn_hit = |learn_match;
      learn_idx = r.repl;
      for (int i = TBL_ENTRIES - 1; i >= 0; i--) begin
         if (look_match[i]) begin
            look_port = ent_port[i];
         end
         if (learn_match[i]) begin
            learn_idx = TBL_AW'(i);
         end
      end
      if (learn_en && !learn_hit) begin
         next_r.repl = r.repl + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r <= '{repl: REPL_RESET};
         for (int i = 0; i < TBL_ENTRIES; i++) begin
            ent_vld[i] <= 1'b0;
         end
      end else begin
         r <= next_r;
         if (learn_en) begin
            ent_vld[learn_idx] <= 1'b1;
            ent_mac[learn_idx] <= learn_mac;
            ent_port[learn_idx] <= learn_port;
         end
      end
   end

   chk_entry_move: assert property (@(posedge core_clk) disable iff (sys_rst)
      (learn_en && learn_hit) |=> ent_port[$past(learn_idx)] == $past(learn_port))
      else $error("known station not moved to new port");
   chk_entry_store: assert property (@(posedge core_clk) disable iff (sys_rst)
      learn_en |=> ent_vld[$past(learn_idx)] && ent_mac[$past(learn_idx)] == $past(learn_mac))
      else $error("learned entry not stored");
endmodule

// File: design/l2fe_engine.sv
// store-and-forward frame engine with learning, forwarding and port speed resolution
`timescale 1ns/1ns
module l2fe_engine
   import l2fe_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [NPORT-1:0] in_valid,
   input wire logic [NPORT-1:0][7:0] in_data,
   input wire logic [NPORT-1:0] in_last,
   input wire logic [NPORT-1:0] in_bad,
   output logic [NPORT-1:0] in_ready,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_last,
   output logic [NPORT-1:0] out_port_mask,
   input wire logic out_ready,
   input wire logic [NPORT-1:0] link_pin,
   input wire logic [NPORT-1:0][AB_W-1:0] an_partner,
   output logic [NPORT-1:0] port_up,
   output logic [NPORT-1:0][1:0] port_speed,
   output logic [NPORT-1:0] port_full
);
   typedef struct packed {
      l2fe_state_t st;
      logic [PORT_W-1:0] port;
      logic [LEN_W-1:0] len;
      logic [LEN_W-1:0] rd;
      logic [MAC_W-1:0] da;
      logic [MAC_W-1:0] sa;
      logic bad;
      logic [NPORT-1:0] mask;
      logic [7:0] odata;
      logic [NPORT-1:0] s1;
      logic [NPORT-1:0] s2;
      logic [NPORT-1:0] s3;
      logic [NPORT-1:0] lnk;
      logic [NPORT-1:0] up;
      logic [NPORT-1:0] full;
      logic [NPORT-1:0][1:0] spd;
   } l2fe_eng_t;

   l2fe_eng_t r;
   l2fe_eng_t next_r;
   logic [7:0] frame_buf [BUF_DEPTH];
   logic buf_we;
   logic [BUF_AW-1:0] buf_wa;
   logic tbl_hit;
   logic [PORT_W-1:0] tbl_port;
   logic tbl_learn;
   logic [NPORT-1:0] src_onehot;
   logic [NPORT-1:0] hit_onehot;
   logic [AB_W-1:0] common;
   logic take;
   logic [LEN_W-1:0] len_inc;

   l2fe_addr_table u_table (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .look_mac(r.da),
      .look_hit(tbl_hit),
      .look_port(tbl_port),
      .learn_en(tbl_learn),
      .learn_mac(r.sa),
      .learn_port(r.port)
   );

   assign src_onehot = NPORT'(1) << r.port;
   assign hit_onehot = NPORT'(1) << tbl_port;
   assign tbl_learn = (r.st == ST_DECIDE) && !r.bad;
   assign take = (r.st == ST_STORE) && in_valid[r.port];
   assign len_inc = r.len + 1'b1;
   assign buf_we = take && (r.len <= BUF_LAST);
   assign buf_wa = r.len[BUF_AW-1:0];

   assign in_ready = (r.st == ST_STORE) ? src_onehot : '0;
   assign out_valid = (r.st == ST_SEND);
   assign out_data = r.odata;
   assign out_last = (r.st == ST_SEND) && (r.rd == r.len);
   assign out_port_mask = r.mask;
   assign port_up = r.up;
   assign port_speed = r.spd;
   assign port_full = r.full;

   always_comb begin
      next_r = r;
      common = '0;
      // port link sampling and speed resolution
      next_r.s1 = link_pin;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int p = 0; p < NPORT; p++) begin
         if (r.s2[p] == r.s3[p]) begin
            next_r.lnk[p] = r.s2[p];
         end
         if (!next_r.lnk[p]) begin
            next_r.up[p] = 1'b0;
         end else if (!r.lnk[p]) begin
            common = an_partner[p] & LOCAL_ABILITY;
            next_r.up[p] = |common;
            next_r.full[p] = 1'b0;
            next_r.spd[p] = SPD_10;
            if (common[AB_1000F]) begin
               next_r.spd[p] = SPD_1000;
               next_r.full[p] = 1'b1;
            end else if (common[AB_100F]) begin
               next_r.spd[p] = SPD_100;
               next_r.full[p] = 1'b1;
            end else if (common[AB_100H]) begin
               next_r.spd[p] = SPD_100;
            end else if (common[AB_10F]) begin
               next_r.full[p] = 1'b1;
            end
         end
      end
      unique case (r.st)
         ST_IDLE: begin
            for (int p = NPORT - 1; p >= 0; p--) begin
               if (in_valid[p] && r.up[p]) begin
                  next_r.port = PORT_W'(p);
                  next_r.st = ST_STORE;
               end
            end
            next_r.len = '0;
            next_r.bad = 1'b0;
         end
         ST_STORE: begin
            if (take) begin
               if (r.len < DA_END) begin
                  next_r.da = {r.da[MAC_W-9:0], in_data[r.port]};
               end else if (r.len < HDR_BYTES) begin
                  next_r.sa = {r.sa[MAC_W-9:0], in_data[r.port]};
               end
               if (r.len <= BUF_LAST) begin
                  next_r.len = len_inc;
               end else begin
                  next_r.bad = 1'b1;
               end
               if (in_last[r.port]) begin
                  next_r.bad = next_r.bad || in_bad[r.port] || (len_inc < HDR_BYTES);
                  next_r.st = ST_DECIDE;
               end
            end
         end
         ST_DECIDE: begin
            if (r.bad) begin
               next_r.mask = '0;
            end else if (!tbl_hit) begin
               next_r.mask = r.up & ~src_onehot;
            end else if (tbl_port != r.port) begin
               next_r.mask = hit_onehot & r.up;
            end else begin
               next_r.mask = '0;
            end
            next_r.odata = frame_buf[0];
            next_r.rd = 12'h0001;
            next_r.st = (next_r.mask == '0) ? ST_IDLE : ST_SEND;
         end
         ST_SEND: begin
            if (out_ready) begin
               if (r.rd == r.len) begin
                  next_r.st = ST_IDLE;
                  next_r.mask = '0;
               end else begin
                  next_r.odata = frame_buf[r.rd[BUF_AW-1:0]];
                  next_r.rd = r.rd + 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
      if (buf_we) begin
         frame_buf[buf_wa] <= in_data[r.port];
      end
   end

   chk_store_no_send: assert property (@(posedge core_clk) disable iff (sys_rst)
      (r.st == ST_STORE) |-> !out_valid && out_port_mask == '0)
      else $error("output active while frame still arriving");
   chk_bad_dropped: assert property (@(posedge core_clk) disable iff (sys_rst)
      (r.st == ST_DECIDE && r.bad) |=> r.st == ST_IDLE && out_port_mask == '0)
      else $error("failed frame forwarded");
   chk_dest_search: assert property (@(posedge core_clk) disable iff (sys_rst)
      (r.st == ST_DECIDE) |-> u_table.look_mac == r.da)
      else $error("lookup not on destination");
   chk_src_learn: assert property (@(posedge core_clk) disable iff (sys_rst)
      (r.st == ST_DECIDE && !r.bad) |-> tbl_learn && u_table.learn_port == r.port)
      else $error("source not learned");
   chk_miss_flood: assert property (@(posedge core_clk) disable iff (sys_rst)
      (r.st == ST_DECIDE && !r.bad && !tbl_hit) |=> r.mask == ($past(r.up) & ~$past(src_onehot)))
      else $error("miss not flooded");
   chk_hit_forward: assert property (@(posedge core_clk) disable iff (sys_rst)
      (r.st == ST_DECIDE && !r.bad && tbl_hit && tbl_port != r.port) |=>
         r.mask == ($past(hit_onehot) & $past(r.up)))
      else $error("hit not sent to stored port");
   chk_hit_filter: assert property (@(posedge core_clk) disable iff (sys_rst)
      (r.st == ST_DECIDE && !r.bad && tbl_hit && tbl_port == r.port) |=>
         r.st == ST_IDLE && out_port_mask == '0 ##1 !out_valid)
      else $error("same-port frame not filtered");

   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp++) begin : g_an_chk
         chk_gig_full: assert property (@(posedge core_clk) disable iff (sys_rst)
            (r.up[gp] && r.spd[gp] == SPD_1000) |-> r.full[gp])
            else $error("1000 without full duplex");
         chk_best_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
            (next_r.lnk[gp] && !r.lnk[gp] && an_partner[gp][AB_100F] && !an_partner[gp][AB_1000F])
               |=> r.up[gp] && r.spd[gp] == SPD_100 && r.full[gp])
            else $error("best common mode not chosen");
      end
   endgenerate
endmodule

// File: tb/l2fe_sink.sv
// egress sink standing for the remote stations, accepting bytes with random stalls
`timescale 1ns/1ns
module l2fe_sink (
   input wire logic core_clk,
   output logic out_ready
);
   integer seed = 49;
   initial begin
      out_ready = 1'b0;
      forever begin
         @(posedge core_clk);
         #1;
         out_ready = ({$random(seed)} % 4) != 0;
      end
   end
endmodule

// File: tb/tb_top.sv
// self-checking bench of the forwarding engine against a queue-based reference model
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
   import l2fe_pkg::*;
   logic core_clk, sys_rst, out_valid, out_last, out_ready;
   logic [NPORT-1:0] in_valid, in_last, in_bad, in_ready, out_port_mask, link_pin, port_up, port_full, up_m;
   logic [NPORT-1:0][7:0] in_data;
   logic [NPORT-1:0][AB_W-1:0] an_partner;
   logic [NPORT-1:0][1:0] port_speed;
   logic [7:0] out_data;
   logic [7:0] fb[64];
   logic [7:0] exp_d[$];
   logic exp_l[$];
   logic [NPORT-1:0] exp_m[$];
   logic [PORT_W-1:0] tbl[logic [MAC_W-1:0]];
   logic [4:0] abl[8] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00, 5'h06, 5'h1F};
   integer bad_count = 0, cmp_count = 0, seed = 49, sending = 0;
   int k, j, n;
   logic bd;
   l2fe_engine DUT (.core_clk(core_clk), .sys_rst(sys_rst), .in_valid(in_valid), .in_data(in_data),
      .in_last(in_last), .in_bad(in_bad), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
      .out_last(out_last), .out_port_mask(out_port_mask), .out_ready(out_ready), .link_pin(link_pin),
      .an_partner(an_partner), .port_up(port_up), .port_speed(port_speed), .port_full(port_full));
   l2fe_sink u_sink (.core_clk(core_clk), .out_ready(out_ready));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      logic [7:0] ed;
      logic el;
      logic [NPORT-1:0] em;
      if (sending != 0) `CHK(out_valid, 1'b0)
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         if (exp_d.size() == 0) `CHK(out_valid, 1'b0)
         else begin
            ed = exp_d.pop_front();
            el = exp_l.pop_front();
            em = exp_m.pop_front();
            `CHK(out_data, ed)
            `CHK(out_last, el)
            `CHK(out_port_mask, em)
         end
      end
   end
   task automatic report_and_stop();
      if (bad_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   function automatic logic [3:0] best(input logic [4:0] a);
      if (a[AB_1000F]) return {2'b11, SPD_1000};
      if (a[AB_100F]) return {2'b11, SPD_100};
      if (a[AB_100H]) return {2'b10, SPD_100};
      if (a[AB_10F]) return {2'b11, SPD_10};
      if (a[AB_10H]) return {2'b10, SPD_10};
      return 4'h0;
   endfunction
   task automatic link(input int p, input logic [4:0] a);
      logic [3:0] e;
      e = best(a);
      link_pin[p] = 1'b0;
      repeat (8) @(posedge core_clk);
      #1;
      an_partner[p] = a;
      link_pin[p] = 1'b1;
      repeat (12) @(posedge core_clk);
      #1;
      `CHK(port_up[p], e[3])
      if (e[3]) `CHK(port_full[p], e[2])
      if (e[3]) `CHK(port_speed[p], e[1:0])
      up_m[p] = e[3];
   endtask
   task automatic send_frame(input int p, input int len, input logic bad);
      int i, g;
      i = 0;
      g = 0;
      sending = 1;
      while (i < len && g < 500) begin
         in_valid[p] = 1'b1;
         in_data[p] = fb[i];
         in_last[p] = (i == len - 1);
         in_bad[p] = bad && (i == len - 1);
         #2;
         if (in_ready[p] === 1'b1) i++;
         g++;
         @(posedge core_clk);
         #1;
      end
      in_valid[p] = 1'b0;
      in_last[p] = 1'b0;
      in_bad[p] = 1'b0;
      sending = 0;
      `CHK(i, len)
   endtask
   task automatic frame(input int p, input int da, input int sa, input int len, input logic bad);
      logic [MAC_W-1:0] dm, sm;
      logic [NPORT-1:0] m;
      int i, g;
      dm = 48'h0200_0000_0000 + da;
      sm = 48'h0200_0000_0000 + sa;
      for (i = 0; i < len; i++) fb[i] = 8'($random(seed));
      for (i = 0; i < 6; i++) begin
         fb[i] = dm[47-8*i -: 8];
         fb[i+6] = sm[47-8*i -: 8];
      end
      m = 4'h0;
      if (!tbl.exists(dm)) m = up_m & ~(4'h1 << p);
      else if (tbl[dm] != p) m = up_m & (4'h1 << tbl[dm]);
      if (bad) m = 4'h0;
      if (!bad) tbl[sm] = PORT_W'(p);
      if (m != 0) for (i = 0; i < len; i++) begin
         exp_d.push_back(fb[i]);
         exp_l.push_back(i == len - 1);
         exp_m.push_back(m);
      end
      send_frame(p, len, bad);
      g = 0;
      while (exp_d.size() != 0 && g < 400) begin
         @(posedge core_clk);
         g++;
      end
      repeat (4) @(posedge core_clk);
      #1;
      `CHK(exp_d.size(), 0)
   endtask
   initial begin
      #100000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      sys_rst = 1'b1;
      in_valid = '0;
      in_data = '0;
      in_last = '0;
      in_bad = '0;
      link_pin = '0;
      an_partner = '0;
      up_m = '0;
      repeat (10) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      `CHK(port_up, 4'h0)
      foreach (abl[i]) link(0, abl[i]);
      link(1, 5'h0C);
      link(2, 5'h03);
      link(3, 5'h00);
      // a port without a common mode must not be taken
      in_valid[3] = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      `CHK(in_ready, 4'h0)
      in_valid[3] = 1'b0;
      frame(0, 1, 0, 20, 1'b0);
      frame(1, 0, 1, 12, 1'b0);
      frame(0, 0, 0, 16, 1'b0);
      frame(2, 1, 8, 14, 1'b1);
      frame(2, 3, 0, 13, 1'b0);
      frame(1, 0, 1, 15, 1'b0);
      repeat (12) begin
         k = {$random(seed)} % 3;
         bd = ({$random(seed)} % 4) == 0;
         j = bd ? 9 : {$random(seed)} % 4;
         n = 12 + {$random(seed)} % 20;
         frame(k, {$random(seed)} % 4, j, n, bd);
      end
      report_and_stop();
   end
endmodule
